// >>> hdl/rpc_consts.svh
// constants for the rectifier protection and restart controller
`ifndef RPC_CONSTS_SVH
`define RPC_CONSTS_SVH
`define RPC_CLK_HZ 100000000
`define RPC_DEBOUNCE_MS 10
`define RPC_MS_PER_S 1000
`define RPC_SEC_W 6
`define RPC_GRACE_S 6'd20
`define RPC_RESTART_S 6'd1
`define RPC_OT_WARN_S 6'd10
`define RPC_WINDOW_S 6'd60
`define RPC_OV_TRIES 2'd3
`define RPC_N_DB 3
`define RPC_DB_PIN 0
`define RPC_DB_DIP 1
`define RPC_DB_TRIM 2
`define RPC_DB_RESET 3'b111
`define RPC_N_SRC 4
`define RPC_SRC_PIN 0
`define RPC_SRC_DIP 1
`define RPC_SRC_OP 2
`define RPC_SRC_SER 3
`define RPC_SRC_ANALOG 4'b0111
`define RPC_SRC_SERIAL 4'b1000
`endif

// >>> hdl/rpc_pkg.sv
// types for the rectifier protection and restart controller
package rpc_pkg;
  typedef struct packed {
    logic on_off_pin_n;
    logic onoff_dip_on;
    logic trim_dip_on;
    logic protocol_open;
    logic serial_mode_output_enable;
  } rpc_ctrl_t;
  typedef struct packed {
    logic overcurrent;
    logic overvoltage;
    logic overtemp;
  } rpc_fault_t;
  typedef struct packed {
    logic valid;
    logic turn_on;
  } rpc_op_cmd_t;
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_START = 3'h1,
    ST_RUN = 3'h2,
    ST_OT_WARN = 3'h3,
    ST_WAIT = 3'h4,
    ST_LATCH = 3'h5
  } rpc_state_t;
  typedef enum logic [1:0] {
    SP_TRIM_POT = 2'h0,
    SP_MARGIN = 2'h1,
    SP_SERIAL = 2'h2
  } rpc_sp_src_t;
endpackage

// >>> hdl/rpc_restart_ctrl.sv
// protection, restart and mode sequencer for the rectifier main output
`timescale 1ns/1ns
`include "rpc_consts.svh"

// Overview of operation
// - at power-up hold current limiting instead of overload shutdown, up to 20 s
// - overload still present after 20 s: shut output down, then restart
// - overcurrent and overtemperature shutdowns auto-restart, never latch
// - overvoltage: up to three restarts, each after 1 s, in a 1 min window
// - three failed restarts inside one window latch the output off
// - window ends with fewer shutdowns: clear count; next overvoltage shutdown opens a fresh window
// - on/off pin or DIP switch cycled off then on clears the latch
// - removing and reapplying input power clears the latch
// - management off then on operation command clears latch and restarts
// - protocol input pulled down selects serial mode; open selects analog
// - analog and management-bus operation is the reset default
// - serial mode disregards the analog control signals
// - trim DIP off: pot disabled, set-point taken from margining input
// - trim DIP switched off: set-point reverts to factory default
// - trim DIP assumed on at reset, pot active
// - serial mode ignores trim pot and trim DIP for the set-point
// - on/off DIP off: output on only while pin held low; pin ignored serially
// - overtemp: warning low ~10 s before shutdown, released on restart
// - serial mode: serial enable pin is on/off; ignored otherwise
module rpc_restart_ctrl
  import rpc_pkg::*;
#(
  parameter int TICK_CYCLES = `RPC_CLK_HZ,
  parameter int DB_CYCLES = `RPC_CLK_HZ / `RPC_MS_PER_S * `RPC_DEBOUNCE_MS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // input power and protection sensing
  input wire logic input_power_ok,
  input wire rpc_fault_t fault,
  // host pins, switches and management command
  input wire rpc_ctrl_t ctrl,
  input wire rpc_op_cmd_t op_cmd,
  // output control and status
  output logic main_output_on,
  output logic current_limit_active,
  output logic overheat_warning_n,
  output logic latched_off,
  output logic rs485_mode,
  output rpc_sp_src_t sp_source,
  output logic sp_default_load
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int DW = $clog2(DB_CYCLES + 1);

  if (TICK_CYCLES < 2 || DB_CYCLES < 2) begin : g_bad_param
    $error("rpc_restart_ctrl: TICK_CYCLES and DB_CYCLES must be at least 2");
  end

  function automatic logic prescale_wrap(input logic [TW-1:0] cnt);
    return cnt == TW'(TICK_CYCLES - 1);
  endfunction

  // debounce of pin and switches
  logic [`RPC_N_DB-1:0] db_raw;
  logic [`RPC_N_DB-1:0] db_stable_reg;
  logic [`RPC_N_DB-1:0] db_stable_next;
  logic [DW-1:0] db_cnt_reg [`RPC_N_DB];
  logic [DW-1:0] db_cnt_next [`RPC_N_DB];

  assign db_raw = {ctrl.trim_dip_on, ctrl.onoff_dip_on, ctrl.on_off_pin_n};

  always_comb begin
    db_stable_next = db_stable_reg;
    for (int i = 0; i < `RPC_N_DB; i++) begin
      db_cnt_next[i] = '0;
      if (db_raw[i] != db_stable_reg[i]) begin
        // input must hold its new level for the whole period
        if (db_cnt_reg[i] == DW'(DB_CYCLES - 1)) begin
          db_stable_next[i] = db_raw[i];
        end else begin
          db_cnt_next[i] = db_cnt_reg[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      db_stable_reg <= `RPC_DB_RESET;
      for (int i = 0; i < `RPC_N_DB; i++) begin
        db_cnt_reg[i] <= '0;
      end
    end else begin
      db_stable_reg <= db_stable_next;
      db_cnt_reg <= db_cnt_next;
    end
  end

  // sequencer
  rpc_state_t state_reg, state_next;
  logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
  logic [`RPC_SEC_W-1:0] sec_reg, sec_next;
  logic [TW-1:0] win_tick_reg, win_tick_next;
  logic [`RPC_SEC_W-1:0] win_sec_reg, win_sec_next;
  logic win_active_reg, win_active_next;
  logic [1:0] ov_cnt_reg, ov_cnt_next;
  logic ot_wait_reg, ot_wait_next;
  logic op_on_reg, op_on_next;
  logic [`RPC_N_SRC-1:0] off_seen_reg, off_seen_next;
  logic main_on_reg, main_on_next;
  logic cc_reg, cc_next;
  logic warn_n_reg, warn_n_next;
  logic latched_reg, latched_next;
  logic rs485_reg, rs485_next;
  rpc_sp_src_t sp_src_reg, sp_src_next;
  logic sp_load_reg, sp_load_next;

  logic serial;
  logic enable;
  logic ov_shut;
  logic latch_clear;
  logic [`RPC_N_SRC-1:0] src_on;
  logic [`RPC_N_SRC-1:0] src_mask;

  always_comb begin
    serial = rs485_reg;
    src_on = '0;
    src_on[`RPC_SRC_PIN] = ~db_stable_reg[`RPC_DB_PIN];
    src_on[`RPC_SRC_DIP] = db_stable_reg[`RPC_DB_DIP];
    src_on[`RPC_SRC_OP] = op_on_reg;
    src_on[`RPC_SRC_SER] = ctrl.serial_mode_output_enable;
    src_mask = serial ? `RPC_SRC_SERIAL : `RPC_SRC_ANALOG;
    if (serial) begin
      enable = src_on[`RPC_SRC_SER];
    end else begin
      // pin only matters while the on/off DIP is off
      enable = (src_on[`RPC_SRC_DIP] | src_on[`RPC_SRC_PIN]) & src_on[`RPC_SRC_OP];
    end
    latch_clear = enable & |(off_seen_reg & src_on & src_mask);

    rs485_next = ~ctrl.protocol_open;
    op_on_next = op_on_reg;
    if (op_cmd.valid && !serial) begin
      op_on_next = op_cmd.turn_on;
    end

    state_next = state_reg;
    ov_shut = 1'b0;
    ot_wait_next = ot_wait_reg;
    unique case (state_reg)
      ST_OFF: begin
        if (enable && input_power_ok) begin
          state_next = ST_START;
        end
      end
      ST_START, ST_RUN: begin
        if (!enable) begin
          state_next = ST_OFF;
        end else if (fault.overvoltage) begin
          ov_shut = 1'b1;
        end else if (fault.overtemp) begin
          state_next = ST_OT_WARN;
        end else if (state_reg == ST_RUN && fault.overcurrent) begin
          state_next = ST_WAIT;
        end else if (state_reg == ST_START && sec_reg == `RPC_GRACE_S) begin
          state_next = fault.overcurrent ? ST_WAIT : ST_RUN;
        end
      end
      ST_OT_WARN: begin
        if (!enable) begin
          state_next = ST_OFF;
        end else if (fault.overvoltage) begin
          ov_shut = 1'b1;
        end else if (!fault.overtemp) begin
          state_next = ST_RUN;
        end else if (sec_reg == `RPC_OT_WARN_S) begin
          state_next = ST_WAIT;
          ot_wait_next = 1'b1;
        end
      end
      ST_WAIT: begin
        if (!enable) begin
          state_next = ST_OFF;
        end else if (sec_reg >= `RPC_RESTART_S && !(ot_wait_reg && fault.overtemp)) begin
          // restart passes through the grace period again
          state_next = ST_START;
        end
      end
      ST_LATCH: begin
        if (latch_clear) begin
          state_next = ST_START;
        end
      end
      default: state_next = ST_OFF;
    endcase

    ov_cnt_next = ov_cnt_reg;
    win_active_next = win_active_reg;
    if (ov_shut) begin
      win_active_next = 1'b1;
      if (ov_cnt_reg == `RPC_OV_TRIES) begin
        state_next = ST_LATCH;
      end else begin
        state_next = ST_WAIT;
        ov_cnt_next = ov_cnt_reg + 1'b1;
      end
    end

    // window has its own prescaler so state changes do not skew it
    win_tick_next = '0;
    win_sec_next = '0;
    if (win_active_reg && state_reg != ST_LATCH) begin
      win_tick_next = prescale_wrap(win_tick_reg) ? '0 : win_tick_reg + 1'b1;
      win_sec_next = win_sec_reg + (prescale_wrap(win_tick_reg) ? 1'b1 : 1'b0);
      if (prescale_wrap(win_tick_reg) && win_sec_reg == `RPC_WINDOW_S - 1'b1 && !ov_shut) begin
        win_active_next = 1'b0;
        ov_cnt_next = '0;
        win_sec_next = '0;
      end
    end else if (win_active_reg) begin
      win_tick_next = win_tick_reg;
      win_sec_next = win_sec_reg;
    end

    if (state_next != ST_WAIT && state_next != ST_OT_WARN) begin
      ot_wait_next = 1'b0;
    end

    off_seen_next = '0;
    if (state_reg == ST_LATCH && !latch_clear) begin
      off_seen_next = off_seen_reg | (~src_on & src_mask);
    end

    // input power loss drops the output and forgets the overvoltage history
    if (!input_power_ok) begin
      state_next = ST_OFF;
      ov_cnt_next = '0;
      win_active_next = 1'b0;
      win_tick_next = '0;
      win_sec_next = '0;
      ot_wait_next = 1'b0;
      off_seen_next = '0;
    end

    // state timer restarts on every state change
    tick_cnt_next = '0;
    sec_next = '0;
    if (state_next == state_reg) begin
      tick_cnt_next = prescale_wrap(tick_cnt_reg) ? '0 : tick_cnt_reg + 1'b1;
      sec_next = sec_reg;
      if (prescale_wrap(tick_cnt_reg) && sec_reg != '1) begin
        sec_next = sec_reg + 1'b1;
      end
    end

    main_on_next = state_next == ST_START || state_next == ST_RUN || state_next == ST_OT_WARN;
    cc_next = state_next == ST_START && fault.overcurrent;
    warn_n_next = !(state_next == ST_OT_WARN || (state_next == ST_WAIT && ot_wait_next));
    latched_next = state_next == ST_LATCH;

    if (serial) begin
      sp_src_next = SP_SERIAL;
    end else if (db_stable_reg[`RPC_DB_TRIM]) begin
      sp_src_next = SP_TRIM_POT;
    end else begin
      sp_src_next = SP_MARGIN;
    end
    sp_load_next = !serial && db_stable_reg[`RPC_DB_TRIM] && !db_stable_next[`RPC_DB_TRIM];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_OFF;
      tick_cnt_reg <= '0;
      sec_reg <= '0;
      win_tick_reg <= '0;
      win_sec_reg <= '0;
      win_active_reg <= 1'b0;
      ov_cnt_reg <= '0;
      ot_wait_reg <= 1'b0;
      op_on_reg <= 1'b1;
      off_seen_reg <= '0;
      main_on_reg <= 1'b0;
      cc_reg <= 1'b0;
      warn_n_reg <= 1'b1;
      latched_reg <= 1'b0;
      rs485_reg <= 1'b0;
      sp_src_reg <= SP_TRIM_POT;
      sp_load_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      sec_reg <= sec_next;
      win_tick_reg <= win_tick_next;
      win_sec_reg <= win_sec_next;
      win_active_reg <= win_active_next;
      ov_cnt_reg <= ov_cnt_next;
      ot_wait_reg <= ot_wait_next;
      op_on_reg <= op_on_next;
      off_seen_reg <= off_seen_next;
      main_on_reg <= main_on_next;
      cc_reg <= cc_next;
      warn_n_reg <= warn_n_next;
      latched_reg <= latched_next;
      rs485_reg <= rs485_next;
      sp_src_reg <= sp_src_next;
      sp_load_reg <= sp_load_next;
    end
  end

  assign main_output_on = main_on_reg;
  assign current_limit_active = cc_reg;
  assign overheat_warning_n = warn_n_reg;
  assign latched_off = latched_reg;
  assign rs485_mode = rs485_reg;
  assign sp_source = sp_src_reg;
  assign sp_default_load = sp_load_reg;

endmodule // rpc_restart_ctrl

// >>> tb/rpc_restart_ctrl_props.sv
// assertions on the restart controller ports
`timescale 1ns/1ns
module rpc_restart_ctrl_props
  import rpc_pkg::*;
#(
  parameter int TICK_CYCLES = 20
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // inputs
  input wire logic input_power_ok,
  input wire rpc_fault_t fault,
  input wire rpc_ctrl_t ctrl,
  // outputs
  input wire logic main_output_on,
  input wire logic current_limit_active,
  input wire logic overheat_warning_n,
  input wire logic latched_off,
  input wire logic rs485_mode,
  input wire rpc_sp_src_t sp_source,
  input wire logic sp_default_load
);
  localparam int GRACE = 20 * TICK_CYCLES + 2;
  int cl_reg;
  int cl_next;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // grace is far too long for a repetition, so count it
  always_comb cl_next = current_limit_active ? cl_reg + 1 : 0;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) cl_reg <= 0;
    else cl_reg <= cl_next;
  end
  sequence ov_trip;
    ##[1:2] !main_output_on;
  endsequence
  sequence held_off;
    !main_output_on [*8];
  endsequence
  grace_limit_a: assert property (cl_reg <= GRACE)
    else $error("current limit held too long");
  grace_cause_a: assert property (
    current_limit_active |-> main_output_on && $past(fault.overcurrent))
    else $error("current limit without overload");
  ov_restart_a: assert property (
    main_output_on && overheat_warning_n && fault.overvoltage |-> ov_trip ##0 held_off)
    else $error("overvoltage not held off");
  power_loss_a: assert property (
    !input_power_ok |=> !main_output_on && !latched_off)
    else $error("power loss kept output or latch");
  latch_off_a: assert property (latched_off |-> !main_output_on)
    else $error("output on while latched");
  warn_cause_a: assert property (
    $fell(overheat_warning_n) |-> $past(fault.overtemp) || $past(fault.overtemp, 2))
    else $error("warning without overtemperature");
  mode_copy_a: assert property (1'b1 |=> rs485_mode == !$past(ctrl.protocol_open))
    else $error("mode does not follow protocol input");
  serial_src_a: assert property (
    rs485_mode && $past(rs485_mode) |-> sp_source == SP_SERIAL)
    else $error("serial mode set-point source wrong");
  revert_pulse_a: assert property (
    sp_default_load |-> !rs485_mode ##1 !sp_default_load)
    else $error("default load strobe malformed");
endmodule // rpc_restart_ctrl_props

bind rpc_restart_ctrl rpc_restart_ctrl_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
  .core_clk, .resetn, .input_power_ok, .fault, .ctrl, .main_output_on,
  .current_limit_active, .overheat_warning_n, .latched_off, .rs485_mode,
  .sp_source, .sp_default_load);

// >>> tb/rpc_host_model.sv
// host side: control pins, switches and management commands
`timescale 1ns/1ns
module rpc_host_model
  import rpc_pkg::*;
#(
  parameter int HOLD = 8
) (
  // clock
  input wire logic core_clk,
  // pins and command
  output rpc_ctrl_t ctrl,
  output rpc_op_cmd_t op_cmd
);
  // pin off, both switches on, protocol open, serial enable on
  initial ctrl = 5'b11111;
  initial op_cmd = '0;
  // level held past the debounce time before the next change
  task put(input rpc_ctrl_t c);
    @(posedge core_clk) ctrl <= c;
    repeat (HOLD) @(posedge core_clk);
  endtask
  // one pulse per command, so off then on are two commands
  task op(input logic turn_on);
    @(posedge core_clk) op_cmd <= {1'b1, turn_on};
    @(posedge core_clk) op_cmd <= 2'h0;
    repeat (HOLD) @(posedge core_clk);
  endtask
endmodule // rpc_host_model

// >>> tb/tb_top.sv
// self-checking bench for the restart controller
`timescale 1ns/1ns
module tb_top
  import rpc_pkg::*;
();
  localparam int TK = 20;
  logic core_clk;
  logic resetn;
  logic pwr;
  rpc_fault_t flt;
  rpc_ctrl_t ctrl;
  rpc_op_cmd_t op;
  logic on, clim, warn_n, lat, rs, ld;
  rpc_sp_src_t src;
  int error_cnt = 0;
  int checked = 0;
  int loads = 0;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  rpc_host_model #(.HOLD(8)) i_host (.core_clk, .ctrl, .op_cmd(op));
  rpc_restart_ctrl #(.TICK_CYCLES(TK), .DB_CYCLES(4)) i_dut (.core_clk, .resetn,
    .input_power_ok(pwr), .fault(flt), .ctrl, .op_cmd(op), .main_output_on(on),
    .current_limit_active(clim), .overheat_warning_n(warn_n), .latched_off(lat),
    .rs485_mode(rs), .sp_source(src), .sp_default_load(ld));
  always @(posedge core_clk) if (ld === 1'b1) loads++;
  task chk(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // bounded wait for the output level; d returns cycles waited
  task wo(input logic v, input int n, output int d);
    for (d = 0; d < n && on !== v; d++) begin
      @(posedge core_clk);
      #1;
    end
    chk("output", on, v);
    if (on !== v) complete_run();
  endtask
  task ov(input logic last);
    int d;
    @(posedge core_clk) flt.overvoltage <= 1'b1;
    @(posedge core_clk) flt.overvoltage <= 1'b0;
    wo(1'b0, 4, d);
    if (!last) begin
      wo(1'b1, TK + 10, d);
      chk("retry delay", d > TK - 4, 1'b1);
    end
  endtask
  task latch();
    repeat (3) ov(1'b0);
    ov(1'b1);
    chk("latched", lat, 1'b1);
  endtask
  task pw();
    int d;
    @(posedge core_clk) pwr <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk("latch", lat, 1'b0);
    @(posedge core_clk) pwr <= 1'b1;
    wo(1'b1, 10, d);
  endtask
  task t_reset();
    repeat (2) @(posedge core_clk);
    #1;
    chk("output", on, 1'b0);
    chk("mode", rs, 1'b0);
    chk("source", src, SP_TRIM_POT);
    chk("warn", warn_n, 1'b1);
    $display("test reset done");
  endtask
  task t_grace();
    int d;
    @(posedge core_clk);
    pwr <= 1'b1;
    flt.overcurrent <= 1'b1;
    wo(1'b1, 5, d);
    chk("limit", clim, 1'b1);
    wo(1'b0, 20 * TK + 5, d);
    chk("grace", d > 20 * TK - 5, 1'b1);
    @(posedge core_clk) flt.overcurrent <= 1'b0;
    wo(1'b1, TK + 10, d);
    $display("test grace done");
  endtask
  task t_latch();
    int d;
    latch();
    i_host.put(5'b10111);
    i_host.put(5'b11111);
    wo(1'b1, 20, d);
    chk("latch", lat, 1'b0);
    pw();
    latch();
    pw();
    latch();
    i_host.op(1'b0);
    i_host.op(1'b1);
    wo(1'b1, 20, d);
    chk("latch", lat, 1'b0);
    pw();
    $display("test latch done");
  endtask
  task t_window();
    repeat (3) ov(1'b0);
    repeat (60 * TK) @(posedge core_clk);
    ov(1'b0);
    chk("latch", lat, 1'b0);
    $display("test window done");
  endtask
  task t_ot();
    int d;
    repeat (20 * TK + 2) @(posedge core_clk);
    flt.overtemp <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("warn", warn_n, 1'b0);
    chk("output", on, 1'b1);
    wo(1'b0, 10 * TK + 5, d);
    chk("warn time", d > 10 * TK - 5, 1'b1);
    @(posedge core_clk) flt.overtemp <= 1'b0;
    wo(1'b1, TK + 10, d);
    chk("warn", warn_n, 1'b1);
    $display("test overtemp done");
  endtask
  task t_mode();
    int d;
    i_host.put(5'b11010);
    chk("source", src, SP_MARGIN);
    chk("revert", 8'(loads), 8'h01);
    chk("output", on, 1'b1);
    i_host.put(5'b11100);
    chk("mode", rs, 1'b1);
    chk("source", src, SP_SERIAL);
    wo(1'b0, 4, d);
    i_host.put(5'b00001);
    wo(1'b1, 10, d);
    i_host.put(5'b10001);
    chk("output", on, 1'b1);
    chk("revert", 8'(loads), 8'h01);
    // management off must be refused in serial mode
    i_host.op(1'b0);
    chk("output", on, 1'b1);
    // back to analog: DIP off and pin high keep the output off
    i_host.put(5'b10011);
    chk("mode", rs, 1'b0);
    chk("output", on, 1'b0);
    chk("source", src, SP_MARGIN);
    i_host.put(5'b00011);
    chk("output", on, 1'b1);
    $display("test mode done");
  endtask
  initial begin
    resetn <= 1'b0;
    pwr <= 1'b0;
    flt <= '0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_grace();
    t_latch();
    t_window();
    t_ot();
    t_mode();
    complete_run();
  end
endmodule // tb_top
